/* File: hdl/hvdac_pkg.sv */
// shared constants, field layout and decode helper of the high-voltage dac control core
package hvdac_pkg;

	// ----------------------------------------------------------------
	// serial word layout
	// ----------------------------------------------------------------
	localparam int WORD_BITS = 16;
	localparam int DATA_BITS = 12;
	localparam int RW_POS = 15;
	localparam int ADDR_MSB = 14;
	localparam int ADDR_LSB = 12;
	localparam logic [2:0] ADDR_INPUT = 3'h1;
	localparam logic [2:0] ADDR_CTRL = 3'h7;

	// ----------------------------------------------------------------
	// link bit counting (count of rising serial clock edges seen)
	// ----------------------------------------------------------------
	localparam logic [4:0] CNT_LAST_IN = 5'h0f;
	localparam logic [4:0] CNT_READ_START = 5'h04;
	localparam logic [4:0] CNT_READ_END = 5'h10;
	localparam logic [4:0] CNT_STOP = 5'h11;

	// ----------------------------------------------------------------
	// control register fields and reset values
	// ----------------------------------------------------------------
	localparam int ALARM_BIT = 0;
	localparam int POWERUP_BIT = 2;
	localparam int PDMODE_BIT = 6;
	localparam logic [11:0] CTRL_RESET = 12'h040;
	localparam logic [11:0] CODE_RESET = 12'h000;

	// ----------------------------------------------------------------
	// output transfer: vout = code / 4096 * range
	// ----------------------------------------------------------------
	localparam logic [15:0] RANGE_HI_MV = 16'h7530; // 30000 mv
	localparam logic [15:0] RANGE_LO_MV = 16'hea60; // 60000 mv
	localparam int CODE_SHIFT = 12; // divide by 4096

	// register select decode, used by write and read paths
	function automatic logic hvdac_sel(input logic [15:0] word, input logic [2:0] code);
		return word[ADDR_MSB:ADDR_LSB] == code;
	endfunction

endpackage

/* File: hdl/hvdac_sync.sv */
// two-flip-flop level synchroniser for a bundle of independent bits
`timescale 1ns/1ps
`default_nettype none
module hvdac_sync #(
	parameter int W = 5
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} hvdac_sync_s;

	hvdac_sync_s q, d;

	// first stage feeds only the second stage
	always_comb begin
		d = q;
		d.s1 = async_in;
		d.s2 = q.s1;
	end

	always_ff @(posedge clock) begin
		if (!rstn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_out = q.s2;

endmodule
`default_nettype wire

/* File: hdl/hvdac_link.sv */
// serial-clock side: frame shifting, word hand-off and register readback
`timescale 1ns/1ps
`default_nettype none
module hvdac_link (
	input wire logic sclk,
	input wire logic rstn,
	input wire logic sync_n,
	input wire logic sdi,
	input wire logic [11:0] rb_input,
	input wire logic [11:0] rb_ctrl,
	output logic [15:0] word,
	output logic word_tog,
	output logic sdo,
	output logic sdo_oe
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [4:0] cnt;
		logic [15:0] shift;
		logic [11:0] rd_sr;
		logic oe;
		logic sdo;
		logic [23:0] mi1;
		logic [23:0] mi2;
	} hvdac_frame_s;

	typedef struct packed {
		logic [15:0] word;
		logic tog;
	} hvdac_held_s;

	hvdac_frame_s f_q, f_d;
	hvdac_held_s h_q, h_d;
	logic frame_rst;
	logic [15:0] next_shift;

	// sclk stops between frames, so frame state is ended by sync_n itself
	assign frame_rst = sync_n | ~rstn;
	assign next_shift = {f_q.shift[14:0], sdi};

	// shift msb first, hand the 16th bit over as a toggle event
	always_comb begin
		f_d = f_q;
		h_d = h_q;
		f_d.shift = next_shift;
		f_d.mi1 = {rb_input, rb_ctrl};
		f_d.mi2 = f_q.mi1;
		if (f_q.cnt != hvdac_pkg::CNT_STOP) begin
			f_d.cnt = f_q.cnt + 5'h01;
		end
		if (f_q.cnt == hvdac_pkg::CNT_LAST_IN) begin
			h_d.word = next_shift;
			h_d.tog = ~h_q.tog;
		end
		// read flag and select are complete before the 5th edge
		if (f_q.cnt == hvdac_pkg::CNT_READ_START && f_q.shift[3]) begin
			f_d.oe = 1'b1;
			if (hvdac_pkg::hvdac_sel({f_q.shift[3:0], 12'h000}, hvdac_pkg::ADDR_CTRL)) begin
				f_d.rd_sr = {f_q.mi2[10:0], 1'b0};
				f_d.sdo = f_q.mi2[11];
			end else if (hvdac_pkg::hvdac_sel({f_q.shift[3:0], 12'h000}, hvdac_pkg::ADDR_INPUT)) begin
				f_d.rd_sr = {f_q.mi2[22:12], 1'b0};
				f_d.sdo = f_q.mi2[23];
			end else begin
				f_d.rd_sr = 12'h000;
				f_d.sdo = 1'b0;
			end
		end else if (f_q.oe) begin
			f_d.sdo = f_q.rd_sr[11];
			f_d.rd_sr = {f_q.rd_sr[10:0], 1'b0};
			if (f_q.cnt == hvdac_pkg::CNT_READ_END) begin
				f_d.oe = 1'b0;
			end
		end
	end

	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			f_q <= '0;
		end else begin
			f_q <= f_d;
		end
	end

	always_ff @(posedge sclk or negedge rstn) begin
		if (!rstn) begin
			h_q <= '0;
		end else begin
			h_q <= h_d;
		end
	end

	assign word = h_q.word;
	assign word_tog = h_q.tog;
	assign sdo = f_q.sdo;
	assign sdo_oe = f_q.oe;

endmodule
`default_nettype wire

/* File: hdl/hvdac_core.sv */
// digital control core of a single-channel 12-bit high-voltage dac
`timescale 1ns/1ps
`default_nettype none
module hvdac_core (
	input wire logic clock,
	input wire logic rstn,
	input wire logic sclk,
	input wire logic sync_n,
	input wire logic sdi,
	input wire logic load_output_strobe_n,
	input wire logic async_clear_input_n,
	input wire logic range_sel,
	input wire logic over_temp,
	output logic sdo,
	output logic sdo_oe,
	output logic [11:0] dac_code,
	output logic [15:0] vout_mv,
	output logic analog_on,
	output logic out_hiz,
	output logic out_gnd_20k,
	output logic range_30v,
	output logic alarm_n
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [11:0] ctrl;
		logic [11:0] input_code;
		logic [11:0] dac;
		logic range_hi;
		logic [15:0] vout;
		logic on;
		logic hiz;
		logic gnd;
		logic alarm_n;
		logic load_output_strobe_prev;
		logic clr_prev;
		logic tog_prev;
	} hvdac_core_s;

	// reset image built from the shared reset values
	localparam hvdac_core_s RST = '{
		ctrl: hvdac_pkg::CTRL_RESET,
		input_code: hvdac_pkg::CODE_RESET,
		dac: hvdac_pkg::CODE_RESET,
		range_hi: 1'b0,
		vout: 16'h0000,
		on: 1'b0,
		hiz: 1'b0,
		gnd: 1'b1,
		alarm_n: 1'b1,
		// the synchronisers leave reset at 0, so the edge memories start there too;
		// an idle-high pin then shows a rise, never a false falling edge
		load_output_strobe_prev: 1'b0,
		clr_prev: 1'b0,
		tog_prev: 1'b0
	};

	hvdac_core_s q, d;

	// ----------------------------------------------------------------
	// link side and crossings
	// ----------------------------------------------------------------
	logic [15:0] link_word;
	logic link_tog;
	logic [4:0] pins_s;
	logic load_output_strobe_s;
	logic clr_s;
	logic range_s;
	logic hot_s;
	logic tog_s;

	// frame logic runs on the serial clock; registers are mirrored back for readback
	hvdac_link u_link (
		.sclk(sclk),
		.rstn(rstn),
		.sync_n(sync_n),
		.sdi(sdi),
		.rb_input(q.input_code),
		.rb_ctrl(q.ctrl),
		.word(link_word),
		.word_tog(link_tog),
		.sdo(sdo),
		.sdo_oe(sdo_oe)
	);

	// pins and the word toggle pass two flops before use; the word itself is
	// read only after its toggle arrives, by which time it has long settled
	hvdac_sync #(
		.W(5)
	) u_sync (
		.clock(clock),
		.rstn(rstn),
		.async_in({load_output_strobe_n, async_clear_input_n, range_sel, over_temp, link_tog}),
		.sync_out(pins_s)
	);

	assign load_output_strobe_s = pins_s[4];
	assign clr_s = pins_s[3];
	assign range_s = pins_s[2];
	assign hot_s = pins_s[1];
	assign tog_s = pins_s[0];

	// ----------------------------------------------------------------
	// decode and event detection
	// ----------------------------------------------------------------
	logic word_ev;
	logic wr_ev;
	logic wr_input;
	logic wr_ctrl;
	logic load_output_strobe_fall;
	logic clr_fall;
	logic auto_load;
	logic [11:0] wdata;
	logic [11:0] ctrl_n;
	logic [11:0] input_n;
	logic [11:0] dac_n;
	logic range_n;
	logic on_n;
	logic [27:0] product;

	// a new word is any change of the toggle
	assign word_ev = tog_s ^ q.tog_prev;
	assign wr_ev = word_ev & ~link_word[hvdac_pkg::RW_POS];
	assign wr_input = wr_ev & hvdac_pkg::hvdac_sel(link_word, hvdac_pkg::ADDR_INPUT);
	assign wr_ctrl = wr_ev & hvdac_pkg::hvdac_sel(link_word, hvdac_pkg::ADDR_CTRL);
	assign wdata = link_word[hvdac_pkg::DATA_BITS-1:0];

	// strobes act on edges; clear low also masks every load
	assign load_output_strobe_fall = q.load_output_strobe_prev & ~load_output_strobe_s & clr_s;
	assign clr_fall = q.clr_prev & ~clr_s;
	// strobe held low means the dac follows each input write
	assign auto_load = wr_input & ~load_output_strobe_s & clr_s;

	// ----------------------------------------------------------------
	// register updates
	// ----------------------------------------------------------------

	// control register: written by the host, alarm bit set by the sensor
	always_comb begin
		ctrl_n = q.ctrl;
		if (wr_ctrl) begin
			ctrl_n = wdata;
		end
		// set wins over a clearing write in the same cycle
		if (hot_s) begin
			ctrl_n[hvdac_pkg::ALARM_BIT] = 1'b1;
		end
	end

	// input and dac registers, updated whatever the power state
	always_comb begin
		input_n = q.input_code;
		dac_n = q.dac;
		range_n = q.range_hi;
		if (wr_input) begin
			input_n = wdata;
		end
		if (auto_load) begin
			dac_n = wdata;
			range_n = range_s;
		end else if (load_output_strobe_fall) begin
			dac_n = q.input_code;
			range_n = range_s;
		end
		// clear beats a write or load landing in the same cycle
		if (clr_fall) begin
			input_n = hvdac_pkg::CODE_RESET;
			dac_n = hvdac_pkg::CODE_RESET;
		end
	end

	// power state only gates the analog side; codes are untouched
	// thermal shutdown acts like clearing the powerup bit
	assign on_n = ctrl_n[hvdac_pkg::POWERUP_BIT] & ~ctrl_n[hvdac_pkg::ALARM_BIT];

	// range is latched at each dac load (not at a clear), so a pin change waits for the next load
	assign product = 28'(dac_n) * 28'(range_n ? hvdac_pkg::RANGE_HI_MV : hvdac_pkg::RANGE_LO_MV);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		d = q;
		d.tog_prev = tog_s;
		d.load_output_strobe_prev = load_output_strobe_s;
		d.clr_prev = clr_s;
		d.ctrl = ctrl_n;
		d.input_code = input_n;
		d.dac = dac_n;
		d.range_hi = range_n;
		d.vout = product[27:hvdac_pkg::CODE_SHIFT];
		d.on = on_n;
		// while off, the mode bit picks three-state or the 20k pull to ground
		d.hiz = ~on_n & ~ctrl_n[hvdac_pkg::PDMODE_BIT];
		d.gnd = ~on_n & ctrl_n[hvdac_pkg::PDMODE_BIT];
		d.alarm_n = ~ctrl_n[hvdac_pkg::ALARM_BIT];
	end

	// synchronous reset; registers and link stay alive in power-down
	always_ff @(posedge clock) begin
		if (!rstn) begin
			q <= RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, all straight from state flops
	// ----------------------------------------------------------------
	assign dac_code = q.dac;
	assign vout_mv = q.vout;
	assign analog_on = q.on;
	assign out_hiz = q.hiz;
	assign out_gnd_20k = q.gnd;
	assign range_30v = q.range_hi;
	assign alarm_n = q.alarm_n;

endmodule
`default_nettype wire

/* File: bench/hvdac_assertions.sv */
// port checks of the dac control core
`timescale 1ns/1ps
`default_nettype none
module hvdac_checker (
	input wire logic clock,
	input wire logic rstn,
	input wire logic sync_n,
	input wire logic load_output_strobe_n,
	input wire logic async_clear_input_n,
	input wire logic over_temp,
	input wire logic sdo_oe,
	input wire logic [11:0] dac_code,
	input wire logic [15:0] vout_mv,
	input wire logic analog_on,
	input wire logic out_hiz,
	input wire logic out_gnd_20k,
	input wire logic range_30v,
	input wire logic alarm_n
);
	// ----
	// ideal voltage
	// ----
	// full product kept so truncation matches
	logic [27:0] prod;
	assign prod = dac_code * (range_30v ? hvdac_pkg::RANGE_HI_MV : hvdac_pkg::RANGE_LO_MV);
	default clocking @(posedge clock); endclocking
	default disable iff (!rstn);
	// ----
	// checks
	// ----
	reset_vals_a: assert property (disable iff (1'b0)
		!rstn |=> dac_code == 12'h000 && !analog_on && out_gnd_20k && alarm_n) else $error("reset state wrong");
	out_state_a: assert property ($onehot({analog_on, out_hiz, out_gnd_20k}))
		else $error("output state not one-hot");
	code_hold_a: assert property ($changed(analog_on) |-> $stable(dac_code))
		else $error("power change moved code");
	vout_calc_a: assert property (($stable(dac_code) && $stable(range_30v)) [*2] |-> vout_mv == prod[27:12])
		else $error("vout wrong");
	alarm_set_a: assert property (over_temp [*3] |-> ##[0:6] !alarm_n)
		else $error("alarm not raised");
	alarm_off_a: assert property (!alarm_n [*2] |-> !analog_on)
		else $error("channel on in alarm");
	sdo_idle_a: assert property (sync_n [*2] |-> !sdo_oe)
		else $error("sdo driven outside frame");
	load_only_a: assert property ($changed(dac_code) |->
		!$past(load_output_strobe_n, 2) || !$past(async_clear_input_n, 2)) else $error("code moved without load");
	cover property ($rose(analog_on));
	cover property ($fell(alarm_n));
	cover property ($rose(sdo_oe));
endmodule
bind hvdac_core hvdac_checker chk (.clock(clock), .rstn(rstn), .sync_n(sync_n),
	.load_output_strobe_n(load_output_strobe_n), .async_clear_input_n(async_clear_input_n),
	.over_temp(over_temp), .sdo_oe(sdo_oe), .dac_code(dac_code), .vout_mv(vout_mv), .analog_on(analog_on),
	.out_hiz(out_hiz), .out_gnd_20k(out_gnd_20k), .range_30v(range_30v), .alarm_n(alarm_n));
`default_nettype wire

/* File: bench/hvdac_host.sv */
// serial host model sending frames to the core
`timescale 1ns/1ps
`default_nettype none
module hvdac_host (
	output logic sclk,
	output logic sync_n,
	output logic sdi,
	input wire logic sdo,
	input wire logic sdo_oe
);
	// ----
	// frames
	// ----
	// link clock idles low, runs only inside frames
	initial begin
		sclk = 1'b0;
		sync_n = 1'b1;
		sdi = 1'b0;
	end
	// one whole word msb first, readback taken from edge 5
	task automatic frame(input logic [15:0] w, output logic [15:0] r);
		r = 16'h0000;
		sync_n = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			sdi = w[i];
			#7.5 sclk = 1'b1;
			#1 if (i <= 11) r[i] = sdo;
			#6.5 sclk = 1'b0;
		end
		#7.5 sync_n = 1'b1;
		sdi = ~sdi; // released line must not keep its level
	endtask
endmodule
`default_nettype wire

/* File: bench/test_hv_dac_power_and_code_control.sv */
// self-checking bench of the dac control core
`timescale 1ns/1ps
`default_nettype none
module test_hv_dac_power_and_code_control;
	logic clock = 1'b0;
	logic rstn, load_output_strobe_n, range_sel, over_temp, sclk, sync_n, sdi, sdo, sdo_oe;
	logic async_clear_input_n;
	logic analog_on, out_hiz, out_gnd_20k, range_30v, alarm_n;
	logic [11:0] dac_code;
	logic [15:0] vout_mv, rd;
	int fails = 0;
	int n_compared = 0;
	// ----
	// clock, partner, design
	// ----
	// system clock
	always #5 clock = ~clock;
	hvdac_host host (.sclk(sclk), .sync_n(sync_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe));
	hvdac_core uut (.clock(clock), .rstn(rstn), .sclk(sclk), .sync_n(sync_n), .sdi(sdi),
		.load_output_strobe_n(load_output_strobe_n), .async_clear_input_n(async_clear_input_n), .range_sel(range_sel),
		.over_temp(over_temp), .sdo(sdo), .sdo_oe(sdo_oe), .dac_code(dac_code), .vout_mv(vout_mv),
		.analog_on(analog_on), .out_hiz(out_hiz), .out_gnd_20k(out_gnd_20k), .range_30v(range_30v),
		.alarm_n(alarm_n));
	// ----
	// helpers
	// ----
	// outputs are looked at mid-cycle, away from the edge that launches them
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		@(negedge clock);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic end_sim;
		if (fails == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask
	// eight cycles covers the sync and register latency
	task automatic xfer(input logic [15:0] w);
		@(posedge clock);
		host.frame(w, rd);
		cyc(8);
	endtask
	// strobe kept low five cycles, over the sync minimum
	task automatic pulse;
		@(posedge clock);
		load_output_strobe_n <= 1'b0;
		cyc(5);
		load_output_strobe_n <= 1'b1;
		cyc(8);
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_reset;
		chk(dac_code, 16'h0000, "dac");
		chk({analog_on, out_hiz, out_gnd_20k, alarm_n}, 16'h0003, "pins");
		xfer(16'hf000);
		chk(rd, 16'h0040, "ctrl");
		xfer(16'h9000);
		chk(rd, 16'h0000, "input");
	endtask
	task automatic t_pd_write;
		xfer(16'h1800);
		chk(dac_code, 16'h0000, "no load");
		pulse;
		chk(dac_code, 16'h0800, "dac");
		chk(vout_mv, 16'h7530, "vout 60");
		chk({analog_on, out_gnd_20k}, 16'h0001, "still off");
	endtask
	task automatic t_power;
		xfer(16'h7004);
		chk({analog_on, out_hiz, out_gnd_20k}, 16'h0004, "on");
		chk(dac_code, 16'h0800, "kept");
		xfer(16'hf000);
		chk(rd, 16'h0004, "ctrl on");
		xfer(16'h7000);
		chk({analog_on, out_hiz, out_gnd_20k}, 16'h0002, "hiz");
		xfer(16'h7040);
		chk({analog_on, out_hiz, out_gnd_20k}, 16'h0001, "20k");
	endtask
	task automatic t_range;
		@(posedge clock);
		range_sel <= 1'b1;
		load_output_strobe_n <= 1'b0;
		xfer(16'h1fff);
		load_output_strobe_n <= 1'b1;
		chk(vout_mv, 16'h7528, "vout 30");
		chk(range_30v, 16'h0001, "range");
		xfer(16'h2123);
		xfer(16'h9000);
		chk(rd, 16'h0fff, "bad select");
	endtask
	// clear zeroes both registers and masks load pulses while it is low
	task automatic t_clear;
		@(posedge clock);
		async_clear_input_n <= 1'b0;
		cyc(5);
		chk(dac_code, 16'h0000, "cleared dac");
		xfer(16'h1123);
		pulse;
		chk(dac_code, 16'h0000, "load masked");
		@(posedge clock);
		async_clear_input_n <= 1'b1;
		xfer(16'h9000);
		chk(rd, 16'h0123, "input kept");
	endtask
	task automatic t_alarm;
		xfer(16'h7044);
		chk({analog_on, alarm_n}, 16'h0003, "on before alarm");
		@(posedge clock);
		over_temp <= 1'b1;
		cyc(4);
		over_temp <= 1'b0;
		cyc(8);
		chk({analog_on, alarm_n}, 16'h0000, "alarm");
		xfer(16'hf000);
		chk(rd, 16'h0045, "bit0");
		xfer(16'h7004);
		chk({analog_on, alarm_n}, 16'h0003, "cleared");
	endtask
	// ----
	// main sequence and watchdog
	// ----
	initial begin
		rstn = 1'b0;
		load_output_strobe_n = 1'b1;
		async_clear_input_n = 1'b1;
		range_sel = 1'b0;
		over_temp = 1'b0;
		cyc(2);
		rstn <= 1'b1;
		cyc(1);
		t_reset;
		t_pd_write;
		t_power;
		t_range;
		t_clear;
		t_alarm;
		end_sim;
	end
	// whole run needs well under 10 us
	initial begin
		#200000;
		fails++;
		end_sim;
	end
endmodule
`default_nettype wire
